// ### src/atp_access_port.sv
// Register access port: holding pair and control byte that run single
// task-file read and write transfers on the attached storage bus.
// Assumes the MCU bus is synchronous to i_mclk and the storage bus pins
// are asynchronous; pin inputs pass a two-stage synchroniser.
`timescale 1ns/1ps
module atp_access_port #(
  parameter int CNT_W = 8
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // MCU external data bus
  input  wire logic [15:0] i_xaddr,
  input  wire logic        i_xwr,
  input  wire logic        i_xrd,
  input  wire logic [7:0]  i_xwdata,
  output logic      [7:0]  o_xrdata,
  // Status from the sector counter logic and flush pulse to the sector buffer
  input  wire logic        i_sector_count_msb,
  output logic             o_sector_buffer_flush,
  // Storage device bus
  output logic      [3:0]  o_taskfile_select,
  output logic             o_dior_n,
  output logic             o_diow_n,
  input  wire logic [15:0] i_dd,
  output logic      [15:0] o_dd,
  output logic             o_dd_oe,
  output logic             o_busy
);

  // Elaboration check: every phase count must fit the counter
  initial begin
    if (atp_pkg::ACTIVE_CYC > (1 << CNT_W) || atp_pkg::SETUP_CYC > (1 << CNT_W) ||
        atp_pkg::RECOV_CYC > (1 << CNT_W)) begin
      $error("atp_access_port: CNT_W too small for transfer timing");
    end
  end

  localparam logic [CNT_W-1:0] SETUP_LD  = CNT_W'(atp_pkg::SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] ACTIVE_LD = CNT_W'(atp_pkg::ACTIVE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOV_LD  = CNT_W'(atp_pkg::RECOV_CYC - 1);

  logic [15:0]          dd_s;        // Synchronised storage data bus
  atp_pkg::atp_state_e  state_q;     // Sequencer state
  atp_pkg::atp_state_e  state_d;
  logic [CNT_W-1:0]     cnt_q;       // Cycles left in the current phase
  logic [CNT_W-1:0]     cnt_d;
  logic [7:0]           hold_lo_q;   // Holding pair, low byte
  logic [7:0]           hold_lo_d;
  logic [7:0]           hold_hi_q;   // Holding pair, high byte
  logic [7:0]           hold_hi_d;
  logic [3:0]           sel_q;       // Task-file register select
  logic [3:0]           sel_d;
  logic                 wr_go_q;     // Write start request
  logic                 wr_go_d;
  logic                 rd_go_q;     // Read start request
  logic                 rd_go_d;
  logic                 flush_q;     // One-cycle flush pulse
  logic                 flush_d;
  logic                 is_read_q;   // Current transfer direction
  logic                 is_read_d;
  logic [7:0]           rdata_q;     // Registered bus read data
  logic [7:0]           rdata_d;
  logic [3:0]           tf_q;        // Select driven to the pins
  logic [3:0]           tf_d;
  logic                 dior_n_q;
  logic                 dior_n_d;
  logic                 diow_n_q;
  logic                 diow_n_d;
  logic [15:0]          dd_q;
  logic [15:0]          dd_d;
  logic                 dd_oe_q;
  logic                 dd_oe_d;
  logic                 busy_q;      // Work pending or running, registered for the pin
  logic                 busy_d;
  logic                 wr_low;      // Bus write strobes per register
  logic                 wr_high;
  logic                 wr_ctrl;
  logic                 read_done;   // Last strobe cycle of a read

  // Pin inputs pass two flip-flops before any use
  atp_sync #(
    .W (16)
  ) u_dd_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_dd),
    .o_sync   (dd_s)
  );

  // Address decode of the three byte registers
  assign wr_low    = i_xwr && (i_xaddr == atp_pkg::ADDR_HOLD_LOW);
  assign wr_high   = i_xwr && (i_xaddr == atp_pkg::ADDR_HOLD_HIGH);
  assign wr_ctrl   = i_xwr && (i_xaddr == atp_pkg::ADDR_CONTROL);
  assign read_done = (state_q == atp_pkg::st_strobe) && (cnt_q == '0) && is_read_q;

  // Next-state logic for the sequencer and all registers
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    hold_lo_d = hold_lo_q;
    hold_hi_d = hold_hi_q;
    sel_d     = sel_q;
    wr_go_d   = wr_go_q;
    rd_go_d   = rd_go_q;
    flush_d   = 1'b0;                              // Pulse lasts one cycle
    is_read_d = is_read_q;
    rdata_d   = rdata_q;
    tf_d      = tf_q;
    dior_n_d  = dior_n_q;
    diow_n_d  = diow_n_q;
    dd_d      = dd_q;
    dd_oe_d   = dd_oe_q;

    // Sequencer; hardware clears come first so a same-cycle set wins
    case (state_q)
      atp_pkg::st_idle: begin
        if (rd_go_q || wr_go_q) begin              // Start at once
          is_read_d = rd_go_q;                     // Read has priority
          tf_d      = sel_q;                       // Select onto pins
          dd_d      = {hold_hi_q, hold_lo_q};      // Write data from pair
          dd_oe_d   = !rd_go_q;
          cnt_d     = SETUP_LD;
          state_d   = atp_pkg::st_setup;
        end
      end
      atp_pkg::st_setup: begin
        if (cnt_q == '0) begin
          dior_n_d = !is_read_q;
          diow_n_d = is_read_q;
          cnt_d    = ACTIVE_LD;
          state_d  = atp_pkg::st_strobe;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      atp_pkg::st_strobe: begin
        if (cnt_q == '0) begin
          dior_n_d = 1'b1;
          diow_n_d = 1'b1;
          wr_go_d  = 1'b0;                         // Read also drops write
          if (is_read_q) begin
            rd_go_d = 1'b0;
          end
          cnt_d   = RECOV_LD;
          state_d = atp_pkg::st_recov;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      atp_pkg::st_recov: begin
        if (cnt_q == '0) begin
          dd_oe_d = 1'b0;
          state_d = atp_pkg::st_idle;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = atp_pkg::st_idle;
      end
    endcase

    // Software writes; select is frozen while a transfer runs or is about to
    // start, so the pins and the field never disagree at the start edge
    if (wr_low) begin
      hold_lo_d = i_xwdata;
    end
    if (wr_high) begin
      hold_hi_d = i_xwdata;
    end
    if (wr_ctrl) begin
      if (state_q == atp_pkg::st_idle && !rd_go_q && !wr_go_q) begin
        sel_d = i_xwdata[atp_pkg::CTRL_SEL_LSB +: 4];
      end
      // Go bits act only on a one; writing zero never cancels
      wr_go_d = wr_go_d | i_xwdata[atp_pkg::CTRL_WR_BIT];
      rd_go_d = rd_go_d | i_xwdata[atp_pkg::CTRL_RD_BIT];
      flush_d = i_xwdata[atp_pkg::CTRL_FLUSH_BIT];
    end

    // Returned value wins over a simultaneous software write
    if (read_done) begin
      hold_lo_d = dd_s[7:0];
      if (sel_q == atp_pkg::SEL_DATA_REG) begin
        hold_hi_d = dd_s[15:8];
      end
    end

    // Registered read data; unmapped addresses read zero
    if (i_xrd) begin
      case (i_xaddr)
        atp_pkg::ADDR_HOLD_LOW:  rdata_d = hold_lo_q;
        atp_pkg::ADDR_HOLD_HIGH: rdata_d = hold_hi_q;
        atp_pkg::ADDR_CONTROL:   rdata_d = {sel_q, wr_go_q, rd_go_q, flush_q,
                                            i_sector_count_msb};
        default:                 rdata_d = atp_pkg::RDATA_RST;
      endcase
    end

    // Busy follows the next state so the output flop matches it cycle for cycle
    busy_d = (state_d != atp_pkg::st_idle) || rd_go_d || wr_go_d;
  end

  // Register stage for all state
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_q   <= atp_pkg::st_idle;
      cnt_q     <= CNT_W'(atp_pkg::CNT_RST);
      hold_lo_q <= atp_pkg::HOLD_RST;
      hold_hi_q <= atp_pkg::HOLD_RST;
      sel_q     <= atp_pkg::SEL_RST;
      wr_go_q   <= 1'b0;
      rd_go_q   <= 1'b0;
      flush_q   <= 1'b0;
      is_read_q <= 1'b0;
      rdata_q   <= atp_pkg::RDATA_RST;
      tf_q      <= atp_pkg::SEL_RST;
      dior_n_q  <= 1'b1;
      diow_n_q  <= 1'b1;
      dd_q      <= atp_pkg::DD_RST;
      dd_oe_q   <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      hold_lo_q <= hold_lo_d;
      hold_hi_q <= hold_hi_d;
      sel_q     <= sel_d;
      wr_go_q   <= wr_go_d;
      rd_go_q   <= rd_go_d;
      flush_q   <= flush_d;
      is_read_q <= is_read_d;
      rdata_q   <= rdata_d;
      tf_q      <= tf_d;
      dior_n_q  <= dior_n_d;
      diow_n_q  <= diow_n_d;
      dd_q      <= dd_d;
      dd_oe_q   <= dd_oe_d;
      busy_q    <= busy_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_xrdata              = rdata_q;
  assign o_sector_buffer_flush = flush_q;
  assign o_taskfile_select     = tf_q;
  assign o_dior_n              = dior_n_q;
  assign o_diow_n              = diow_n_q;
  assign o_dd                  = dd_q;
  assign o_dd_oe               = dd_oe_q;
  assign o_busy                = busy_q;

  // Checks
  chk_flush_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    flush_q && !(wr_ctrl && i_xwdata[atp_pkg::CTRL_FLUSH_BIT]) |=> !flush_q)
    else $error("flush pulse longer than one cycle");
  chk_read_clears: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    read_done && !wr_ctrl |=> !rd_go_q && !wr_go_q)
    else $error("read finish left a go bit set");
  chk_read_load: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    read_done |=> hold_lo_q == $past(dd_s[7:0]))
    else $error("read value not loaded into low byte");
  chk_data_full: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    read_done && sel_q == atp_pkg::SEL_DATA_REG |=> hold_hi_q == $past(dd_s[15:8]))
    else $error("data register read lost high byte");
  chk_nondata_high: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    read_done && sel_q != atp_pkg::SEL_DATA_REG && !wr_high |=> $stable(hold_hi_q))
    else $error("non-data read changed high byte");
  chk_write_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state_q == atp_pkg::st_idle && wr_go_q && !rd_go_q
    |=> dd_oe_q && dd_q == $past({hold_hi_q, hold_lo_q}))
    else $error("write transfer not driving holding pair");
  chk_read_priority: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state_q == atp_pkg::st_idle && rd_go_q && wr_go_q |=> is_read_q && !dd_oe_q)
    else $error("write performed despite read request");
  chk_start_prompt: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state_q == atp_pkg::st_idle && rd_go_q |=> state_q == atp_pkg::st_setup
    ##[1:80] !dior_n_q)
    else $error("read transfer did not start");
  chk_select_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state_q != atp_pkg::st_idle |-> tf_q == sel_q)
    else $error("select pins differ from select field");

endmodule

// ### inc/atp_pkg.sv
// Constants and types for the storage-device register access port.
// Assumes a single system clock at CLK_MHZ and an 8-bit external data bus.
package atp_pkg;

  // External data space addresses of the three port registers
  localparam logic [15:0] ADDR_HOLD_LOW  = 16'hF0D2;
  localparam logic [15:0] ADDR_HOLD_HIGH = 16'hF0D3;
  localparam logic [15:0] ADDR_CONTROL   = 16'hF0D4;

  // Control byte field positions
  localparam int CTRL_SEL_LSB   = 4;
  localparam int CTRL_WR_BIT    = 3;
  localparam int CTRL_RD_BIT    = 2;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam int CTRL_SCMSB_BIT = 0;

  // Values after reset
  localparam logic [7:0]  HOLD_RST   = 8'h00;
  localparam logic [3:0]  SEL_RST    = 4'h0;
  localparam logic [7:0]  RDATA_RST  = 8'h00;
  localparam logic [15:0] DD_RST     = 16'h0000;
  localparam logic [7:0]  CNT_RST    = 8'h00;

  // Select code that addresses the 16-bit data register of the task file
  localparam logic [3:0]  SEL_DATA_REG = 4'h0;

  // Transfer timing, printed in ns, counted in clock cycles
  localparam int CLK_MHZ     = 250;
  localparam int T_SETUP_NS  = 70;
  localparam int T_ACTIVE_NS = 290;
  localparam int T_RECOV_NS  = 240;
  // Least times round up to whole cycles
  localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACTIVE_CYC = (T_ACTIVE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_CYC  = (T_RECOV_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_setup,
    st_strobe,
    st_recov
  } atp_state_e;

endpackage

// ### src/atp_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the bits are quasi-static while they are sampled as a group.
`timescale 1ns/1ps
module atp_sync #(
  parameter int W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] sync_q;  // Second stage, safe to use

  initial begin
    if (W < 1) begin
      $error("atp_sync: width must be at least one");
    end
  end

  // Both stages reset to zero so the pin value is never captured at reset
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// ### bench/atp_disk_model.sv
// Behavioural storage device: sixteen task-file registers on the strobed bus.
// Assumes registered, active-low strobes from the access port on i_mclk.
`timescale 1ns/1ps
module atp_disk_model (
  input  wire logic        i_mclk,
  input  wire logic [3:0]  i_select,
  input  wire logic        i_dior_n,
  input  wire logic        i_diow_n,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  output int               o_writes
);
  logic [15:0] regs [16]; // Task-file contents, full width for every code
  logic        wr_q;      // Write strobe one cycle back
  logic [15:0] last;      // Last value put on the bus

  initial begin
    wr_q     = 1'b1;
    last     = 16'h0000;
    o_writes = 0;
    o_rdata  = 16'hFFFF;
  end

  // Writes land on the strobe's rising edge; a released bus shows the
  // inverse of the last value so a stale sample cannot pass by chance
  always @(posedge i_mclk) begin
    if (i_diow_n && !wr_q) begin
      regs[i_select] <= i_wdata;
      o_writes       <= o_writes + 1;
    end
    wr_q <= i_diow_n;
    if (!i_dior_n) begin
      o_rdata <= regs[i_select];
      last    <= regs[i_select];
    end else begin
      o_rdata <= ~last;
    end
  end
endmodule

// ### bench/atp_access_port_tb.sv
// Self-checking bench for the register access port and its storage partner.
// Assumes the package constants and the hand-over timing of the port.
`timescale 1ns/1ps
module atp_access_port_tb;
  logic        i_mclk, i_resetn, i_xwr, i_xrd, i_sector_count_msb;
  logic [15:0] i_xaddr, i_dd, o_dd, hv;
  logic [7:0]  i_xwdata, o_xrdata, mk;
  logic [3:0]  o_taskfile_select;
  logic        o_sector_buffer_flush, o_dior_n, o_diow_n, o_dd_oe, o_busy, rd_seen;
  logic [7:0]  rd_q [$]; // Expected read bytes, oldest first
  int          n_fail, compares, cyc, seed, writes, pulses, mw;

  atp_access_port u_atp_access_port (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_xaddr(i_xaddr), .i_xwr(i_xwr),
    .i_xrd(i_xrd), .i_xwdata(i_xwdata), .o_xrdata(o_xrdata),
    .i_sector_count_msb(i_sector_count_msb), .o_sector_buffer_flush(o_sector_buffer_flush),
    .o_taskfile_select(o_taskfile_select), .o_dior_n(o_dior_n), .o_diow_n(o_diow_n),
    .i_dd(i_dd), .o_dd(o_dd), .o_dd_oe(o_dd_oe), .o_busy(o_busy));

  atp_disk_model u_atp_disk_model (
    .i_mclk(i_mclk), .i_select(o_taskfile_select), .i_dior_n(o_dior_n),
    .i_diow_n(o_diow_n), .i_wdata(o_dd), .o_rdata(i_dd), .o_writes(mw));

  // Free-running 250 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read data stands the cycle after the strobe; oldest note is compared
  always @(posedge i_mclk) begin
    if (rd_seen) begin
      if (rd_q.size() == 0) begin
        n_fail++;
        $display("Error o_xrdata expected none seen %h", o_xrdata);
      end else begin
        chk("o_xrdata", {8'h00, rd_q.pop_front()}, {8'h00, o_xrdata});
      end
    end
    rd_seen <= i_xrd;
    if (o_sector_buffer_flush === 1'b1) pulses++;
    cyc++;
    if (cyc > 20000) begin // Hang guard, far above the ~5300 cycles needed
      n_fail++;
      give_verdict();
    end
  end

  // One-cycle write strobe, driven just after an edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    i_xaddr  = a;
    i_xwdata = d;
    i_xwr    = 1'b1;
    @(posedge i_mclk);
    #1;
    i_xwr = 1'b0;
  endtask

  // One-cycle read strobe; the expected byte goes on the queue first
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge i_mclk);
    #1;
    i_xaddr = a;
    i_xrd   = 1'b1;
    @(posedge i_mclk);
    #1;
    i_xrd = 1'b0;
  endtask

  // Bounded wait for the transfer sequencer to go idle
  task automatic idle_wait;
    int k;
    k = 0;
    while (o_busy !== 1'b0 && k < 400) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk("o_busy", 16'h0000, {15'h0, o_busy});
  endtask

  initial begin
    seed = 73;
    {i_resetn, i_xwr, i_xrd, i_sector_count_msb, rd_seen} = 5'h00;
    i_xaddr  = 16'h0000;
    i_xwdata = 8'h00;
    {n_fail, compares, cyc, pulses} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (4) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    // Reset values, read-only count bit, select field, unmapped place
    i_sector_count_msb = 1'b1;
    rd(atp_pkg::ADDR_HOLD_LOW, 8'h00);
    rd(atp_pkg::ADDR_HOLD_HIGH, 8'h00);
    rd(atp_pkg::ADDR_CONTROL, 8'h01);
    wr(atp_pkg::ADDR_CONTROL, 8'hA0);
    rd(atp_pkg::ADDR_CONTROL, 8'hA1);
    rd(16'hF0D5, 8'h00);
    $display("test registers done");
    // Flush gives exactly one pulse and clears itself
    i_sector_count_msb = 1'b0;
    pulses = 0;
    wr(atp_pkg::ADDR_CONTROL, 8'hA2);
    repeat (4) @(posedge i_mclk);
    chk("flush pulses", 16'h0001, pulses[15:0]);
    rd(atp_pkg::ADDR_CONTROL, 8'hA0);
    $display("test flush done");
    // Write then read back through every select code
    for (int s = 0; s < 16; s++) begin
      hv = 16'($random(seed));
      mk = 8'($random(seed));
      wr(atp_pkg::ADDR_HOLD_LOW, hv[7:0]);
      wr(atp_pkg::ADDR_HOLD_HIGH, hv[15:8]);
      wr(atp_pkg::ADDR_CONTROL, {s[3:0], 4'h8});
      chk("o_busy", 16'h0001, {15'h0, o_busy});
      repeat (2) @(posedge i_mclk);
      chk("select", {12'h0, s[3:0]}, {12'h0, o_taskfile_select});
      chk("o_dd", hv, o_dd);
      chk("o_dd_oe", 16'h0001, {15'h0, o_dd_oe});
      repeat (20) @(posedge i_mclk);
      chk("o_diow_n", 16'h0000, {15'h0, o_diow_n});
      chk("o_dior_n", 16'h0001, {15'h0, o_dior_n});
      idle_wait();
      chk("o_dd_oe", 16'h0000, {15'h0, o_dd_oe});
      chk("stored", hv, u_atp_disk_model.regs[s]);
      wr(atp_pkg::ADDR_HOLD_HIGH, mk);
      wr(atp_pkg::ADDR_CONTROL, {s[3:0], 4'h4});
      repeat (22) @(posedge i_mclk);
      chk("o_dior_n", 16'h0000, {15'h0, o_dior_n});
      chk("o_dd_oe", 16'h0000, {15'h0, o_dd_oe});
      idle_wait();
      rd(atp_pkg::ADDR_HOLD_LOW, hv[7:0]);
      rd(atp_pkg::ADDR_HOLD_HIGH, (s == 0) ? hv[15:8] : mk);
      rd(atp_pkg::ADDR_CONTROL, {s[3:0], 4'h0});
    end
    $display("test transfers done");
    // Both go bits: only the read runs, both bits clear
    writes = mw;
    wr(atp_pkg::ADDR_HOLD_LOW, 8'h3C);
    wr(atp_pkg::ADDR_CONTROL, 8'h6C);
    idle_wait();
    chk("device writes", writes[15:0], mw[15:0]);
    rd(atp_pkg::ADDR_HOLD_LOW, u_atp_disk_model.regs[6][7:0]);
    rd(atp_pkg::ADDR_CONTROL, 8'h60);
    repeat (2) @(posedge i_mclk);
    $display("test read wins done");
    give_verdict();
  end
endmodule
